// ===== src/link_ctrl_pkg.sv
// Constants, register map and state type shared by the link control block.
// Assumes one 50 MHz clock; all users refer to names as link_ctrl_pkg::name.
package link_ctrl_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NPORT  = 2;
  localparam int FLD_W  = 2;
  localparam int PER_W  = 8;
  localparam int PSC_W  = 16;

  localparam logic [ADDR_W-1:0] OFF_MISC  = 8'h22;
  localparam logic [ADDR_W-1:0] OFF_STAT1 = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_STAT2 = 8'h25;
  localparam logic [ADDR_W-1:0] OFF_LIN   = 8'h32;

  localparam logic [DATA_W-1:0] RST_MISC  = 8'h04;
  localparam logic [DATA_W-1:0] RST_LIN   = 8'hc0;
  localparam logic [DATA_W-1:0] LIN_WMASK = 8'hcf;

  localparam int MISC_TERM_BIT  = 7;
  localparam int MISC_LP_LSB    = 5;
  localparam int MISC_LPDIS_BIT = 4;
  localparam int MISC_DFP_LSB   = 2;
  localparam int MISC_SKIP_BIT  = 1;
  localparam int MISC_CMDIS_BIT = 0;

  localparam int STAT_LONG_BIT = 7;
  localparam int STAT_CM_BIT   = 3;
  localparam int STAT_U0_BIT   = 2;
  localparam int STAT_LP_BIT   = 1;
  localparam int STAT_DISC_BIT = 0;

  localparam int LIN_LFPS_LSB = 6;
  localparam int LIN_CONN_LSB = 2;
  localparam int LIN_UP_LSB   = 0;

  // Detect periods in milliseconds, entry n for field code n.
  localparam logic [3:0][PER_W-1:0] LP_PERIOD_MS  = {8'h9c, 8'h78, 8'h54, 8'h30};
  localparam logic [3:0][PER_W-1:0] DFP_PERIOD_MS = {8'h54, 8'h24, 8'h06, 8'h04};

  localparam int CLK_HZ    = 50000000;
  localparam int MS_PER_S  = 1000;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;

  typedef enum logic [2:0] {
    LS_DETECT,
    LS_POLLING,
    LS_U0,
    LS_LOW_POWER,
    LS_COMPLIANCE,
    LS_INACTIVE,
    LS_WARM_RESET
  } link_state_e;

endpackage

// ===== src/sync_2ff.sv
// Two-stage synchroniser for a bundle of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
`timescale 1ns/1ps
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         MCLK,
  input  wire logic         RST,
  input  wire logic         CE,
  input  wire logic [W-1:0] D,
  output logic      [W-1:0] Q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge MCLK) begin
    if (RST) begin
      meta_r <= '0;
      Q      <= '0;
    end else if (CE) begin
      meta_r <= D;
      Q      <= meta_r;
    end
  end

endmodule

// ===== src/detect_timer.sv
// Millisecond interval counter that pulses once per programmed period.
// Assumes a one-cycle millisecond tick from the same clock and enable.
`timescale 1ns/1ps
module detect_timer #(
  parameter int PER_W = 8
) (
  input  wire logic             MCLK,
  input  wire logic             RST,
  input  wire logic             CE,
  input  wire logic             TICK,
  input  wire logic             RUN,
  input  wire logic             RESTART,
  input  wire logic [PER_W-1:0] PERIOD,
  output logic                  EXPIRE
);

  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] cnt_nxt;

  assign cnt_nxt = PER_W'(cnt_r + 1'b1);

  always_ff @(posedge MCLK) begin
    if (RST) begin
      cnt_r  <= '0;
      EXPIRE <= 1'b0;
    end else if (CE) begin
      EXPIRE <= 1'b0;
      if (RESTART || !RUN) begin
        cnt_r <= '0;
      end else if (TICK) begin
        if (cnt_nxt >= PERIOD) begin
          cnt_r  <= '0;
          EXPIRE <= 1'b1;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  end

endmodule

// ===== src/link_ctrl.sv
// Link tracking, receiver-detect scheduling and status registers for two ports.
// Assumes link event pins are asynchronous levels and the register port is synchronous.
//
// Functional notes
// - Termination kept or removed at detect start.
// - Low-power detect period from two-bit code.
// - Disable bit stops detection in U2/U3.
// - Normal detect period from code, reset 6 ms.
// - Skip detect when polling seen in warm reset.
// - Compliance disable bit blocks compliance entry.
// - Long-channel flag, zero when equaliser disabled.
// - Compliance flag follows compliance state.
// - Active flag set on entering U0.
// - Low-power flag set on entering U2/U3.
// - Disconnect flag set on entry, resets high.
// - Linearity register steers transmitter output range.
// - Code zero highest level, code three lowest.
// - Only fast variant reports channel choice.
`timescale 1ns/1ps
module link_ctrl #(
  parameter int TICKS_PER_MS = link_ctrl_pkg::MS_CYCLES
) (
  input  wire logic                               MCLK,
  input  wire logic                               RST,
  input  wire logic                               CE,
  input  wire logic [link_ctrl_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [link_ctrl_pkg::DATA_W-1:0]   WR_DATA,
  input  wire logic                               WR_STB,
  input  wire logic                               RD_STB,
  output logic      [link_ctrl_pkg::DATA_W-1:0]   RD_DATA,
  input  wire logic                               ADAPTIVE_EQ_ENABLE,
  input  wire logic [1:0]                         ADAPTIVE_EQ_VARIANT,
  input  wire logic                               UPSTREAM_LIMITING_ENABLE,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    LONG_CHANNEL,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    FAR_TERM,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    FAR_POLLING,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    LP_ENTRY,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    LP_EXIT,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    WARM_RESET,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    POLL_TIMEOUT,
  input  wire logic [link_ctrl_pkg::NPORT-1:0]    TRAINED,
  output logic      [link_ctrl_pkg::NPORT-1:0]    DETECT_REQ,
  output logic      [link_ctrl_pkg::NPORT-1:0]    TERM_EN,
  output logic      [link_ctrl_pkg::FLD_W-1:0]    UPSTREAM_LINEAR_LEVEL,
  output logic      [link_ctrl_pkg::FLD_W-1:0]    UPSTREAM_TX_SWING,
  output logic      [link_ctrl_pkg::FLD_W-1:0]    CONNECTOR_TX_LEVEL,
  output logic      [link_ctrl_pkg::FLD_W-1:0]    LFPS_TX_LEVEL
);

  localparam int NP = link_ctrl_pkg::NPORT;
  localparam int SW = 7 * link_ctrl_pkg::NPORT;
  localparam logic [link_ctrl_pkg::PSC_W-1:0] TICK_LAST =
    link_ctrl_pkg::PSC_W'(TICKS_PER_MS - 1);

  logic [link_ctrl_pkg::DATA_W-1:0] misc_r;
  logic [link_ctrl_pkg::DATA_W-1:0] lin_r;
  logic [link_ctrl_pkg::PSC_W-1:0]  ms_cnt_r;
  logic                             ms_tick_r;
  logic [SW-1:0]                    pins_s;
  logic [NP-1:0]                    far_s;
  logic [NP-1:0]                    poll_s;
  logic [NP-1:0]                    lpin_s;
  logic [NP-1:0]                    lpout_s;
  logic [NP-1:0]                    warm_s;
  logic [NP-1:0]                    tmo_s;
  logic [NP-1:0]                    trn_s;
  logic [NP-1:0]                    expire;
  logic [NP-1:0]                    tmr_run;
  logic [NP-1:0]                    tmr_restart;
  logic [link_ctrl_pkg::PER_W-1:0]  tmr_period [NP];
  logic [NP-1:0]                    polled_r;
  logic [NP-1:0]                    long_r;
  logic [NP-1:0]                    cm_r;
  logic [NP-1:0]                    u0_r;
  logic [NP-1:0]                    lp_r;
  logic [NP-1:0]                    disc_r;
  link_ctrl_pkg::link_state_e       st_r   [NP];
  link_ctrl_pkg::link_state_e       st_nxt [NP];

  logic [link_ctrl_pkg::FLD_W-1:0] lp_code;
  logic [link_ctrl_pkg::FLD_W-1:0] dfp_code;
  logic                            fast_variant;

  assign lp_code  = misc_r[link_ctrl_pkg::MISC_LP_LSB +: link_ctrl_pkg::FLD_W];
  assign dfp_code = misc_r[link_ctrl_pkg::MISC_DFP_LSB +: link_ctrl_pkg::FLD_W];
  assign fast_variant = !ADAPTIVE_EQ_VARIANT[0];

  function automatic logic [link_ctrl_pkg::FLD_W-1:0] level_of(
    input logic [link_ctrl_pkg::FLD_W-1:0] code);
    level_of = ~code;
  endfunction

  function automatic logic [link_ctrl_pkg::DATA_W-1:0] stat_word(input int p);
    logic [link_ctrl_pkg::DATA_W-1:0] w;
    w = '0;
    w[link_ctrl_pkg::STAT_LONG_BIT] = long_r[p];
    w[link_ctrl_pkg::STAT_CM_BIT]   = cm_r[p];
    w[link_ctrl_pkg::STAT_U0_BIT]   = u0_r[p];
    w[link_ctrl_pkg::STAT_LP_BIT]   = lp_r[p];
    w[link_ctrl_pkg::STAT_DISC_BIT] = disc_r[p];
    return w;
  endfunction

  sync_2ff #(
    .W (SW)
  ) u_sync (
    .MCLK (MCLK),
    .RST  (RST),
    .CE   (CE),
    .D    ({TRAINED, POLL_TIMEOUT, WARM_RESET, LP_EXIT, LP_ENTRY, FAR_POLLING, FAR_TERM}),
    .Q    (pins_s)
  );

  assign {trn_s, tmo_s, warm_s, lpout_s, lpin_s, poll_s, far_s} = pins_s;

  // One shared millisecond tick keeps the per-port timers narrow.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      ms_cnt_r  <= '0;
      ms_tick_r <= 1'b0;
    end else if (CE) begin
      ms_tick_r <= (ms_cnt_r == TICK_LAST);
      if (ms_cnt_r == TICK_LAST) begin
        ms_cnt_r <= '0;
      end else begin
        ms_cnt_r <= link_ctrl_pkg::PSC_W'(ms_cnt_r + 1'b1);
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      misc_r <= link_ctrl_pkg::RST_MISC;
    end else if (CE && WR_STB && ADDR == link_ctrl_pkg::OFF_MISC) begin
      misc_r <= WR_DATA;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      lin_r <= link_ctrl_pkg::RST_LIN;
    end else if (CE && WR_STB && ADDR == link_ctrl_pkg::OFF_LIN) begin
      lin_r <= WR_DATA & link_ctrl_pkg::LIN_WMASK;
    end
  end

  always_ff @(posedge MCLK) begin
    if (RST) begin
      RD_DATA <= '0;
    end else if (CE) begin
      RD_DATA <= '0;
      if (RD_STB) begin
        unique case (ADDR)
          link_ctrl_pkg::OFF_MISC:  RD_DATA <= misc_r;
          link_ctrl_pkg::OFF_STAT1: RD_DATA <= stat_word(0);
          link_ctrl_pkg::OFF_STAT2: RD_DATA <= stat_word(1);
          link_ctrl_pkg::OFF_LIN:   RD_DATA <= lin_r;
          default:                  RD_DATA <= '0;
        endcase
      end
    end
  end

  // Upstream field steers linear or limited driver.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      UPSTREAM_LINEAR_LEVEL <= '0;
      UPSTREAM_TX_SWING     <= '0;
      CONNECTOR_TX_LEVEL    <= '0;
      LFPS_TX_LEVEL         <= '0;
    end else if (CE) begin
      CONNECTOR_TX_LEVEL <= level_of(lin_r[link_ctrl_pkg::LIN_CONN_LSB +: link_ctrl_pkg::FLD_W]);
      LFPS_TX_LEVEL      <= level_of(lin_r[link_ctrl_pkg::LIN_LFPS_LSB +: link_ctrl_pkg::FLD_W]);
      if (UPSTREAM_LIMITING_ENABLE) begin
        UPSTREAM_LINEAR_LEVEL <= '0;
        UPSTREAM_TX_SWING <= level_of(lin_r[link_ctrl_pkg::LIN_UP_LSB +: link_ctrl_pkg::FLD_W]);
      end else begin
        UPSTREAM_TX_SWING     <= '0;
        UPSTREAM_LINEAR_LEVEL <=
          level_of(lin_r[link_ctrl_pkg::LIN_UP_LSB +: link_ctrl_pkg::FLD_W]);
      end
    end
  end

  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  for (genvar p = 0; p < NP; p++) begin : g_port

    assign tmr_period[p] = (st_r[p] == link_ctrl_pkg::LS_LOW_POWER) ?
                           link_ctrl_pkg::LP_PERIOD_MS[lp_code] :
                           link_ctrl_pkg::DFP_PERIOD_MS[dfp_code];
    assign tmr_run[p] = (st_r[p] == link_ctrl_pkg::LS_DETECT) ||
                        (st_r[p] == link_ctrl_pkg::LS_INACTIVE) ||
                        (st_r[p] == link_ctrl_pkg::LS_LOW_POWER &&
                         !misc_r[link_ctrl_pkg::MISC_LPDIS_BIT]);
    assign tmr_restart[p] = (st_nxt[p] != st_r[p]);

    detect_timer #(
      .PER_W (link_ctrl_pkg::PER_W)
    ) u_timer (
      .MCLK    (MCLK),
      .RST     (RST),
      .CE      (CE),
      .TICK    (ms_tick_r),
      .RUN     (tmr_run[p]),
      .RESTART (tmr_restart[p]),
      .PERIOD  (tmr_period[p]),
      .EXPIRE  (expire[p])
    );

    always_comb begin
      st_nxt[p] = st_r[p];
      unique case (st_r[p])
        link_ctrl_pkg::LS_DETECT: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (expire[p] && far_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_POLLING;
          end
        end
        link_ctrl_pkg::LS_POLLING: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (trn_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_U0;
          end else if (tmo_s[p]) begin
            st_nxt[p] = misc_r[link_ctrl_pkg::MISC_CMDIS_BIT] ?
                        link_ctrl_pkg::LS_DETECT : link_ctrl_pkg::LS_COMPLIANCE;
          end
        end
        link_ctrl_pkg::LS_U0: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (lpin_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_LOW_POWER;
          end else if (tmo_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_INACTIVE;
          end
        end
        link_ctrl_pkg::LS_LOW_POWER: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (lpout_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_U0;
          end else if (expire[p] && !far_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_DETECT;
          end
        end
        link_ctrl_pkg::LS_COMPLIANCE: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (misc_r[link_ctrl_pkg::MISC_CMDIS_BIT]) begin
            st_nxt[p] = link_ctrl_pkg::LS_DETECT;
          end
        end
        link_ctrl_pkg::LS_INACTIVE: begin
          if (warm_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_WARM_RESET;
          end else if (expire[p] && !far_s[p]) begin
            st_nxt[p] = link_ctrl_pkg::LS_DETECT;
          end
        end
        link_ctrl_pkg::LS_WARM_RESET: begin
          if (!warm_s[p]) begin
            // Skip detect after polled warm reset.
            st_nxt[p] = (misc_r[link_ctrl_pkg::MISC_SKIP_BIT] && polled_r[p]) ?
                        link_ctrl_pkg::LS_POLLING : link_ctrl_pkg::LS_DETECT;
          end
        end
      endcase
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        st_r[p] <= link_ctrl_pkg::LS_DETECT;
      end else if (CE) begin
        st_r[p] <= st_nxt[p];
      end
    end

    // The polling seen during warm reset is only meaningful for that reset.
    always_ff @(posedge MCLK) begin
      if (RST) begin
        polled_r[p] <= 1'b0;
      end else if (CE) begin
        if (st_r[p] != link_ctrl_pkg::LS_WARM_RESET) begin
          polled_r[p] <= 1'b0;
        end else if (poll_s[p]) begin
          polled_r[p] <= 1'b1;
        end
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        TERM_EN[p] <= 1'b1;
      end else if (CE) begin
        if (st_nxt[p] == link_ctrl_pkg::LS_POLLING) begin
          TERM_EN[p] <= 1'b1;
        end else if ((st_r[p] == link_ctrl_pkg::LS_WARM_RESET &&
                      st_nxt[p] == link_ctrl_pkg::LS_DETECT) ||
                     (st_r[p] != link_ctrl_pkg::LS_INACTIVE &&
                      st_nxt[p] == link_ctrl_pkg::LS_INACTIVE)) begin
          TERM_EN[p] <= !misc_r[link_ctrl_pkg::MISC_TERM_BIT];
        end
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        DETECT_REQ[p] <= 1'b0;
      end else if (CE) begin
        DETECT_REQ[p] <= expire[p];
      end
    end

    // Long-channel flag forced low when disabled.
    always_ff @(posedge MCLK) begin
      if (RST) begin
        long_r[p] <= 1'b0;
      end else if (CE) begin
        long_r[p] <= ADAPTIVE_EQ_ENABLE && fast_variant && LONG_CHANNEL[p];
      end
    end

    always_ff @(posedge MCLK) begin
      if (RST) begin
        cm_r[p]   <= 1'b0;
        u0_r[p]   <= 1'b0;
        lp_r[p]   <= 1'b0;
        disc_r[p] <= 1'b1;
      end else if (CE) begin
        cm_r[p] <= (st_nxt[p] == link_ctrl_pkg::LS_COMPLIANCE);
        if (st_nxt[p] != st_r[p] &&
            (st_nxt[p] == link_ctrl_pkg::LS_U0 ||
             st_nxt[p] == link_ctrl_pkg::LS_LOW_POWER ||
             st_nxt[p] == link_ctrl_pkg::LS_DETECT)) begin
          u0_r[p]   <= (st_nxt[p] == link_ctrl_pkg::LS_U0);
          lp_r[p]   <= (st_nxt[p] == link_ctrl_pkg::LS_LOW_POWER);
          disc_r[p] <= (st_nxt[p] == link_ctrl_pkg::LS_DETECT);
        end
      end
    end

    sequence warm_end_polled;
      CE && st_r[p] == link_ctrl_pkg::LS_WARM_RESET && polled_r[p] && !warm_s[p];
    endsequence

    term_start_a: assert property (
      CE && st_r[p] != link_ctrl_pkg::LS_INACTIVE && st_nxt[p] == link_ctrl_pkg::LS_INACTIVE
      |=> TERM_EN[p] == !$past(misc_r[link_ctrl_pkg::MISC_TERM_BIT]))
      else $error("termination wrong at inactive entry");
    lp_period_a: assert property (
      st_r[p] == link_ctrl_pkg::LS_LOW_POWER
      |-> tmr_period[p] == link_ctrl_pkg::LP_PERIOD_MS[lp_code])
      else $error("low-power detect period wrong");
    lp_detect_off_a: assert property (
      CE && st_r[p] == link_ctrl_pkg::LS_LOW_POWER && misc_r[link_ctrl_pkg::MISC_LPDIS_BIT]
      ##1 CE && st_r[p] == link_ctrl_pkg::LS_LOW_POWER |=> !DETECT_REQ[p])
      else $error("detect issued while low-power detect disabled");
    dfp_period_a: assert property (
      st_r[p] == link_ctrl_pkg::LS_DETECT
      |-> tmr_period[p] == link_ctrl_pkg::DFP_PERIOD_MS[dfp_code])
      else $error("detect period wrong");
    warm_skip_a: assert property (
      warm_end_polled |-> ##1 (st_r[p] == (misc_r[link_ctrl_pkg::MISC_SKIP_BIT] ?
        link_ctrl_pkg::LS_POLLING : link_ctrl_pkg::LS_DETECT)) || $changed(misc_r))
      else $error("warm reset exit state wrong");
    no_compliance_a: assert property (
      CE && misc_r[link_ctrl_pkg::MISC_CMDIS_BIT] && st_r[p] != link_ctrl_pkg::LS_COMPLIANCE
      |=> st_r[p] != link_ctrl_pkg::LS_COMPLIANCE)
      else $error("compliance entered while disabled");
    long_flag_a: assert property (
      CE && !(ADAPTIVE_EQ_ENABLE && fast_variant) |=> !long_r[p])
      else $error("long-channel flag set while not in fast equaliser mode");
    cm_flag_a: assert property (
      cm_r[p] == (st_r[p] == link_ctrl_pkg::LS_COMPLIANCE))
      else $error("compliance flag disagrees with state");
    u0_flag_a: assert property (
      CE && st_r[p] != link_ctrl_pkg::LS_U0 && st_nxt[p] == link_ctrl_pkg::LS_U0
      |=> u0_r[p] && !lp_r[p] && !disc_r[p])
      else $error("active flag not set on entry");
    lp_flag_a: assert property (
      CE && st_r[p] != link_ctrl_pkg::LS_LOW_POWER && st_nxt[p] == link_ctrl_pkg::LS_LOW_POWER
      |=> lp_r[p] && !u0_r[p] && !disc_r[p])
      else $error("low-power flag not set on entry");
    disc_flag_a: assert property (
      CE && st_r[p] != link_ctrl_pkg::LS_DETECT && st_nxt[p] == link_ctrl_pkg::LS_DETECT
      |=> disc_r[p] && !u0_r[p])
      else $error("disconnect flag not set on entry");
    status_hold_a: assert property (
      CE && st_nxt[p] == st_r[p] |=> $stable({u0_r[p], lp_r[p], disc_r[p], cm_r[p]}))
      else $error("status flag moved without state change");
  end

endmodule

// ===== bench/link_partner.sv
// Far link partner: drives the event levels that a USB 3 peer would cause.
// Assumes the bench calls its tasks; every level changes just after a rising edge.
`timescale 1ns/1ps
module link_partner #(
  parameter int RESP_DLY = 2,
  parameter int HOLD     = 4
) (
  input  wire logic       mclk,
  output logic      [1:0] far_term,
  output logic      [1:0] far_poll,
  output logic      [1:0] lp_entry,
  output logic      [1:0] lp_exit,
  output logic      [1:0] warm_rst,
  output logic      [1:0] poll_to,
  output logic      [1:0] trained
);
  logic [1:0] ev_r [0:6];

  initial begin
    for (int i = 0; i < 7; i++) begin
      ev_r[i] = 2'h0;
    end
  end

  assign far_term = ev_r[0];
  assign far_poll = ev_r[1];
  assign lp_entry = ev_r[2];
  assign lp_exit  = ev_r[3];
  assign warm_rst = ev_r[4];
  assign poll_to  = ev_r[5];
  assign trained  = ev_r[6];

  // A slow peer answers some cycles late, so every change waits first.
  task automatic drive_level(input int s, input int p, input logic v);
    repeat (RESP_DLY) @(posedge mclk);
    ev_r[s][p] <= v;
  endtask

  // Events are levels held long enough for the two-flop synchroniser.
  task automatic pulse(input int s, input int p);
    drive_level(s, p, 1'b1);
    repeat (HOLD) @(posedge mclk);
    ev_r[s][p] <= 1'b0;
  endtask
endmodule

// ===== bench/link_ctrl_tb_top.sv
// Self-checking bench for the link control block: registers, detect timing, link events.
// Assumes TICKS_PER_MS is shortened to 10, so one millisecond is ten clocks.
`timescale 1ns/1ps
module link_ctrl_tb_top;
  localparam int TPM = 10;
  localparam int T_TERM = 0, T_POLL = 1, T_LPIN = 2, T_LPOUT = 3;
  localparam int T_WARM = 4, T_TOUT = 5, T_TRAIN = 6;
  int         dfp [4] = '{4, 6, 36, 84};
  int         lp [4] = '{48, 84, 120, 156};
  logic       mclk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic [7:0] rd_data;
  logic       wr_stb = 1'b0;
  logic       rd_stb = 1'b0;
  logic       adaptive_eq_enable = 1'b0;
  logic       lim_en = 1'b0;
  logic [1:0] aeq_var = 2'h0;
  logic [1:0] long_ch = 2'h0;
  logic [1:0] far_term, far_poll, lp_entry, lp_exit, warm_rst, poll_to, trained;
  logic [1:0] det_req, term_en, up_lin, up_swing, conn_lvl, lfps_lvl;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  int         n;

  always #10 mclk = ~mclk;

  link_ctrl #(.TICKS_PER_MS(TPM)) u_link_ctrl (
    .MCLK(mclk), .RST(rst), .CE(ce), .ADDR(addr), .WR_DATA(wr_data),
    .WR_STB(wr_stb), .RD_STB(rd_stb), .RD_DATA(rd_data), .ADAPTIVE_EQ_ENABLE(adaptive_eq_enable),
    .ADAPTIVE_EQ_VARIANT(aeq_var), .UPSTREAM_LIMITING_ENABLE(lim_en),
    .LONG_CHANNEL(long_ch), .FAR_TERM(far_term), .FAR_POLLING(far_poll),
    .LP_ENTRY(lp_entry), .LP_EXIT(lp_exit), .WARM_RESET(warm_rst),
    .POLL_TIMEOUT(poll_to), .TRAINED(trained), .DETECT_REQ(det_req), .TERM_EN(term_en),
    .UPSTREAM_LINEAR_LEVEL(up_lin), .UPSTREAM_TX_SWING(up_swing),
    .CONNECTOR_TX_LEVEL(conn_lvl), .LFPS_TX_LEVEL(lfps_lvl));

  link_partner u_link_partner (
    .mclk(mclk), .far_term(far_term), .far_poll(far_poll), .lp_entry(lp_entry),
    .lp_exit(lp_exit), .warm_rst(warm_rst), .poll_to(poll_to), .trained(trained));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The whole run needs about 13000 cycles, so three times that means a hang.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic idle(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk(nm, {8'h00, rd_data}, {8'h00, e});
  endtask

  // Counts cycles to the next detect pulse; 2000 means none came.
  task automatic wait_req(input int p);
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (det_req[p] !== 1'b1 && n < 2000);
  endtask

  // The first interval after a write may be partial, so the second is measured.
  task automatic per_chk(input logic [7:0] m, input int cycles);
    wr(8'h22, m);
    wait_req(0);
    wait_req(0);
    chk("detect period", 16'(n), 16'(cycles));
  endtask

  initial begin
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    idle(2);
    chk("conn reset", conn_lvl, 16'h3);
    chk("uplin reset", up_lin, 16'h3);
    rd("misc reset", 8'h22, 8'h04);
    rd("stat1 reset", 8'h24, 8'h01);
    rd("stat2 reset", 8'h25, 8'h01);
    rd("lin reset", 8'h32, 8'hc0);
    rd("unmapped", 8'h40, 8'h00);
    wr(8'h24, 8'hfe);
    rd("stat1 write", 8'h24, 8'h01);
    $display("test registers done");
    for (int c = 0; c < 4; c++) begin
      per_chk(8'(c << 2), TPM * dfp[c]);
    end
    wr(8'h22, 8'h04);
    $display("test detect period done");
    u_link_partner.drive_level(T_TERM, 0, 1'b1);
    idle(4);
    wait_req(0);
    u_link_partner.pulse(T_TRAIN, 0);
    idle(3);
    rd("stat1 u0", 8'h24, 8'h04);
    @(posedge mclk) long_ch <= 2'h1;
    adaptive_eq_enable <= 1'b1;
    idle(2);
    rd("long fast", 8'h24, 8'h84);
    @(posedge mclk) aeq_var <= 2'h1;
    idle(2);
    rd("long full", 8'h24, 8'h04);
    @(posedge mclk) aeq_var <= 2'h2;
    idle(2);
    rd("long x0", 8'h24, 8'h84);
    @(posedge mclk) adaptive_eq_enable <= 1'b0;
    idle(2);
    rd("long off", 8'h24, 8'h04);
    u_link_partner.pulse(T_LPIN, 0);
    idle(3);
    rd("stat1 lp", 8'h24, 8'h02);
    for (int c = 0; c < 4; c++) begin
      per_chk(8'((c << 5) | 4), TPM * lp[c]);
    end
    wr(8'h22, 8'h14);
    idle(5);
    wait_req(0);
    chk("lp detect off", 16'(n), 16'd2000);
    u_link_partner.pulse(T_LPOUT, 0);
    idle(3);
    rd("stat1 wake", 8'h24, 8'h04);
    wr(8'h22, 8'h84);
    u_link_partner.pulse(T_TOUT, 0);
    idle(3);
    chk("term inactive", term_en[0], 16'h0);
    u_link_partner.drive_level(T_TERM, 0, 1'b0);
    idle(4);
    wait_req(0);
    idle(2);
    rd("stat1 disc", 8'h24, 8'h01);
    $display("test link port one done");
    u_link_partner.drive_level(T_TERM, 1, 1'b1);
    idle(4);
    wait_req(1);
    u_link_partner.pulse(T_TOUT, 1);
    idle(3);
    rd("stat2 cm", 8'h25, 8'h09);
    wr(8'h22, 8'h85);
    idle(3);
    rd("stat2 cm off", 8'h25, 8'h01);
    wait_req(1);
    u_link_partner.pulse(T_TOUT, 1);
    idle(3);
    rd("stat2 no cm", 8'h25, 8'h01);
    u_link_partner.drive_level(T_TERM, 1, 1'b0);
    idle(4);
    for (int s = 0; s < 2; s++) begin
      wr(8'h22, 8'(8'h85 | (s << 1)));
      u_link_partner.drive_level(T_WARM, 1, 1'b1);
      u_link_partner.drive_level(T_POLL, 1, 1'b1);
      idle(4);
      u_link_partner.drive_level(T_WARM, 1, 1'b0);
      idle(6);
      chk("warm term", term_en[1], 16'(s));
      u_link_partner.drive_level(T_POLL, 1, 1'b0);
    end
    $display("test link port two done");
    wr(8'h32, 8'h99);
    rd("lin write", 8'h32, 8'h89);
    idle(1);
    chk("lfps level", lfps_lvl, 16'h1);
    chk("conn level", conn_lvl, 16'h1);
    chk("uplin level", up_lin, 16'h2);
    chk("swing off", up_swing, 16'h0);
    @(posedge mclk) lim_en <= 1'b1;
    idle(2);
    chk("uplin limited", up_lin, 16'h0);
    chk("swing limited", up_swing, 16'h2);
    // A write made while the enable is low must not land.
    @(posedge mclk) ce <= 1'b0;
    wr(8'h32, 8'h00);
    @(posedge mclk) ce <= 1'b1;
    rd("lin frozen", 8'h32, 8'h89);
    $display("test linearity done");
    report_and_stop();
  end
endmodule
